// File: verilog/lds_diag_status.sv
// status and fault logic for the two-channel buck driver
module lds_diag_status #(
	parameter int START_TMO = lds_pkg::START_TMO_CYC, // start-up timeout
	parameter int RUN_TMO   = lds_pkg::RUN_TMO_CYC    // running timeout
) (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       spi_sck_i,
	input  wire logic       spi_cs_n_i,
	input  wire logic       spi_mosi_i,
	output logic            spi_miso_o,
	output logic            spi_miso_oe_o,
	input  wire logic       enable_i,         // device enable, low = off mode
	input  wire logic       supply_above_uv_i,
	input  wire logic       overtemp_i,       // die above shutdown limit
	input  wire logic       gate_supply_in_reg_i,
	input  wire logic [7:0] temp_code_i,      // converter output
	input  wire logic [7:0] diag2_i,          // secondary diagnostic register
	input  wire logic [1:0] pwm_i,
	input  wire logic [1:0] live_current_reached_i,
	input  wire logic [1:0] bs_uv_i,
	input  wire logic [1:0] low_headroom_i,
	input  wire logic       fault_clear_req_i,
	output logic            fault_clear_ack_o, // high while a request is held and no error remains
	output logic            gate_reg_en_o,
	output logic            gate_drv_en_o,
	output logic [1:0]      ch_current_en_o,
	output logic            vled_meas_upd_o,
	output logic [1:0]      recharge_o,        // one-cycle recharge pulses
	output logic [1:0]      bs_comp_en_o,
	output logic [7:0]      status_o,
	output logic [7:0]      die_temperature_o
);
	typedef struct packed {
		lds_pkg::lds_gs_e gs;       // gate supply sequence
		logic [17:0]      gs_cnt;   // out-of-regulation timer
		logic             supply_ok;
		logic             overtemp;
		logic             gs_fault;
		logic             fault_ot; // fault raised with overtemp
		logic             cmd_err;
		logic             clr_ack;
		logic             reg_en;
		logic             drv_en;
		logic             meas;
		logic [7:0]       temp;
		logic [11:0]      tcnt;     // sample interval timer
		logic [1:0]       pwm_p;
		logic [1:0]       tgt;
		logic [1:0][11:0] lowc;     // pwm low duration
		logic [1:0][11:0] rcnt;     // recharge interval
		logic [1:0]       rch;
		logic [1:0]       comp;
		logic [1:0]       cur;
		logic [15:0]      tx;
	} lds_st_s;

	lds_st_s q, d;
	lds_cmd_if cif ();

	// serial engine
	lds_spi_frame u_frame (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.sck_i     (spi_sck_i),
		.cs_n_i    (spi_cs_n_i),
		.mosi_i    (spi_mosi_i),
		.miso_o    (spi_miso_o),
		.miso_oe_o (spi_miso_oe_o),
		.cmd_if    (cif.eng)
	);

	logic       gs_good;   // gate supply good, decoded from state
	logic [7:0] stat;      // live status byte
	logic       wr;
	logic [6:0] adr;
	logic       err;
	logic       fault_set;
	logic       fault_clr;

	// one-hot, so the run state's own bit is the good flag, straight from a flop
	assign gs_good = q.gs[2];
	// reserved bit 2 reads as zero
	assign stat = {q.supply_ok, q.cmd_err, q.overtemp, q.gs_fault, gs_good, 1'b0, q.tgt};
	assign wr  = cif.cmd[lds_pkg::CMD_WR];
	assign adr = cif.cmd[14:8];

	// only temperature and status live here; anything else is reserved
	always_comb begin
		err = 1'b0;
		if (cif.bad) begin
			err = 1'b1;
		end else if (wr && adr != lds_pkg::ADDR_STATUS) begin
			err = 1'b1;
		end else if (!wr && adr != lds_pkg::ADDR_STATUS && adr != lds_pkg::ADDR_TEMP) begin
			err = 1'b1;
		end
	end

	// all next-state logic
	always_comb begin
		d = q;
		fault_set = 1'b0;
		// supply comparator mirrored directly
		d.supply_ok = supply_above_uv_i;
		d.clr_ack = 1'b0;

		// overtemp: set wins; clear only by request once cool
		if (overtemp_i) begin
			d.overtemp = 1'b1;
		end else if (fault_clear_req_i) begin
			d.overtemp = 1'b0;
		end

		// regulator runs only with supply, no faults, enabled
		d.reg_en = q.supply_ok && !q.overtemp && !q.gs_fault && enable_i;

		// gate supply sequencing
		case (q.gs)
			lds_pkg::GS_OFF: begin
				d.gs_cnt = '0;
				if (q.reg_en) begin
					d.gs = lds_pkg::GS_START;
				end
			end
			lds_pkg::GS_START: begin
				// supply loss or off mode must never end in a timeout fault
				if (!q.reg_en || !q.supply_ok || !enable_i) begin
					d.gs = lds_pkg::GS_OFF;
				end else if (gate_supply_in_reg_i) begin
					d.gs = lds_pkg::GS_RUN;
					d.gs_cnt = '0;
				end else if (q.gs_cnt == 18'(START_TMO - 1)) begin
					fault_set = 1'b1;
				end else begin
					d.gs_cnt = q.gs_cnt + 18'h1;
				end
			end
			lds_pkg::GS_RUN: begin
				if (!q.supply_ok) begin
					// undervoltage drops good but may never raise the fault
					d.gs = lds_pkg::GS_OFF;
				end else if (q.overtemp) begin
					// good was high, so fault rides with overtemp
					fault_set = 1'b1;
					d.fault_ot = 1'b1;
				end else if (!q.reg_en || !enable_i) begin
					// off mode leaves quietly instead of timing out
					d.gs = lds_pkg::GS_OFF;
				end else if (gate_supply_in_reg_i) begin
					d.gs_cnt = '0;
				end else if (q.gs_cnt == 18'(RUN_TMO - 1)) begin
					fault_set = 1'b1;
				end else begin
					d.gs_cnt = q.gs_cnt + 18'h1;
				end
			end
			lds_pkg::GS_FAULT: begin
				if (!q.gs_fault) begin
					d.gs = lds_pkg::GS_OFF;
				end
			end
			default: begin
				d.gs = lds_pkg::GS_OFF;
			end
		endcase

		// fault clear: request (with overtemp gone if linked) or off mode
		fault_clr = !enable_i || (fault_clear_req_i && !(q.fault_ot && overtemp_i));
		if (fault_set) begin
			d.gs_fault = 1'b1; // set wins over clear
			d.gs = lds_pkg::GS_FAULT;
			d.gs_cnt = '0;
		end else if (fault_clr) begin
			d.gs_fault = 1'b0;
			d.fault_ot = 1'b0;
		end

		// acknowledge once every error is gone
		d.clr_ack = fault_clear_req_i && !d.overtemp && !d.gs_fault;

		// drivers and measurement
		// supply term cuts the drivers a cycle before the regulator path would
		d.drv_en = q.reg_en && q.supply_ok && gs_good && !q.gs_fault;
		d.meas = q.supply_ok && gs_good && !q.gs_fault;

		// periodic temperature sample, held between samples
		if (q.tcnt == 12'(lds_pkg::TEMP_SMP_CYC - 1)) begin
			d.tcnt = '0;
			d.temp = temp_code_i;
		end else begin
			d.tcnt = q.tcnt + 12'h1;
		end

		// per channel: target flag, recharge, compensation
		d.pwm_p = pwm_i;
		for (int c = 0; c < 2; c++) begin
			// current stops as soon as the supply flag drops
			d.cur[c] = q.drv_en && q.supply_ok && pwm_i[c];
			if (!q.supply_ok) begin
				d.tgt[c] = 1'b0; // cleared on undervoltage
			end else if (q.pwm_p[c] && !pwm_i[c]) begin
				d.tgt[c] = live_current_reached_i[c];
			end
			if (pwm_i[c]) begin
				d.lowc[c] = '0;
			end else if (q.lowc[c] != 12'(lds_pkg::PWM_LOW_CYC)) begin
				d.lowc[c] = q.lowc[c] + 12'h1;
			end
			d.rch[c] = 1'b0;
			// idle switch: long pwm low, or on but current not reached
			if ((!pwm_i[c] && q.lowc[c] == 12'(lds_pkg::PWM_LOW_CYC))
				|| (pwm_i[c] && !live_current_reached_i[c])) begin
				if (q.rcnt[c] == 12'(lds_pkg::RECHARGE_CYC - 1)) begin
					d.rcnt[c] = '0;
					d.rch[c] = 1'b1;
				end else begin
					d.rcnt[c] = q.rcnt[c] + 12'h1;
				end
			end else begin
				d.rcnt[c] = '0;
			end
			d.comp[c] = q.drv_en && !pwm_i[c] && !bs_uv_i[c] && !low_headroom_i[c];
		end

		// command execution
		if (cif.done) begin
			if (err) begin
				// write discarded, diagnostics queued for next access
				d.cmd_err = 1'b1;
				d.tx = {stat, diag2_i};
			end else if (wr) begin
				// only the error bit is writable; data is ignored
				d.cmd_err = 1'b0;
				d.tx = {stat, 8'h00};
			end else if (adr == lds_pkg::ADDR_TEMP) begin
				d.tx = {stat, q.temp};
			end else begin
				d.tx = {stat, stat};
			end
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '{gs: lds_pkg::GS_OFF, temp: lds_pkg::TEMP_RESET,
				tx: lds_pkg::TX_RESET, default: '0};
		end else begin
			q <= d;
		end
	end

	assign cif.tx            = q.tx;
	assign fault_clear_ack_o = q.clr_ack;
	assign gate_reg_en_o     = q.reg_en;
	assign gate_drv_en_o     = q.drv_en;
	assign ch_current_en_o   = q.cur;
	assign vled_meas_upd_o   = q.meas;
	assign recharge_o        = q.rch;
	assign bs_comp_en_o      = q.comp;
	assign die_temperature_o = q.temp;
	// status byte built from flops only
	assign status_o = stat;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	property p_low_no_fault;
		!q.supply_ok && !q.gs_fault |=> !q.gs_fault;
	endproperty
	a_low_no_fault: assert property (p_low_no_fault) else $error("fault set in undervoltage");

	property p_low_off;
		!q.supply_ok |=> (!q.reg_en && !q.drv_en && q.cur == 2'b00);
	endproperty
	a_low_off: assert property (p_low_off) else $error("drivers on in undervoltage");

	property p_err_flag;
		cif.done && cif.bad |=> q.cmd_err && q.tx[7:0] == $past(diag2_i);
	endproperty
	a_err_flag: assert property (p_err_flag) else $error("error not flagged");

	property p_wr_clear;
		cif.done && !err && wr |=> !q.cmd_err && q.supply_ok == $past(supply_above_uv_i);
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("status write misbehaves");

	property p_ot_stop;
		$rose(q.overtemp) |-> ##[1:3] (!q.drv_en && !q.reg_en);
	endproperty
	a_ot_stop: assert property (p_ot_stop) else $error("overtemp left drivers on");

	property p_tgt_edge;
		q.supply_ok && q.pwm_p[0] && !pwm_i[0] |=> q.tgt[0] == $past(live_current_reached_i[0]);
	endproperty
	a_tgt_edge: assert property (p_tgt_edge) else $error("target flag not copied");

	property p_comp;
		q.comp[1] |-> $past(q.drv_en) && !$past(pwm_i[1]) && !$past(bs_uv_i[1]);
	endproperty
	a_comp: assert property (p_comp) else $error("compensation in wrong state");

	property p_temp_hold;
		q.tcnt != 12'h000 |-> $stable(q.temp);
	endproperty
	a_temp_hold: assert property (p_temp_hold) else $error("temperature changed mid-interval");

	property p_fault_meas;
		q.gs_fault |=> !q.meas && !q.drv_en;
	endproperty
	a_fault_meas: assert property (p_fault_meas) else $error("fault left measurement on");

	property p_off_clear;
		!enable_i && !q.overtemp && !overtemp_i |=> !q.gs_fault;
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("off mode kept fault");

	property p_low_good;
		!q.supply_ok |=> !gs_good;
	endproperty
	a_low_good: assert property (p_low_good) else $error("good set in undervoltage");

	property p_ot_fault;
		$rose(q.overtemp) && gs_good && q.supply_ok |=> q.gs_fault;
	endproperty
	a_ot_fault: assert property (p_ot_fault) else $error("overtemp left fault clear");

	property p_meas_gate;
		q.meas |-> $past(q.supply_ok) && !$past(q.gs_fault);
	endproperty
	a_meas_gate: assert property (p_meas_gate) else $error("measurement update not gated");

	property p_rch_idle;
		q.rch[0] |-> !$past(pwm_i[0]) || !$past(live_current_reached_i[0]);
	endproperty
	a_rch_idle: assert property (p_rch_idle) else $error("recharge while switching");

	property p_ack_clean;
		q.clr_ack |-> !q.overtemp && !q.gs_fault;
	endproperty
	a_ack_clean: assert property (p_ack_clean) else $error("clear acknowledged with error");
endmodule : lds_diag_status

// File: verilog/lds_pkg.sv
package lds_pkg;
	localparam logic [6:0]  ADDR_TEMP   = 7'h26; // die temperature, read only
	localparam logic [6:0]  ADDR_STATUS = 7'h37; // primary status
	localparam int          ST_SUPPLY   = 7;     // status field positions
	localparam int          ST_CMD_ERR  = 6;
	localparam int          ST_OVERTEMP = 5;
	localparam int          ST_GS_FAULT = 4;
	localparam int          ST_GS_GOOD  = 3;
	localparam int          CMD_WR      = 15;    // frame: write flag, address, data
	localparam int          FRAME_BITS  = 16;
	localparam logic [7:0]  TEMP_RESET  = 8'h00;
	localparam logic [15:0] TX_RESET    = 16'h0000;
	localparam int          CLK_HZ      = 20_000_000;
	localparam int          START_TMO_MS = 12;   // gate supply start-up timeout
	localparam int          RUN_TMO_MS   = 1;    // gate supply run timeout
	localparam int          START_TMO_CYC = START_TMO_MS * (CLK_HZ / 1000);
	localparam int          RUN_TMO_CYC   = RUN_TMO_MS * (CLK_HZ / 1000);
	localparam int          RECHARGE_US   = 100; // recharge interval
	localparam int          PWM_LOW_US    = 50;  // pwm low recharge delay
	localparam int          TEMP_SMP_US   = 100; // temperature sample interval
	localparam int          RECHARGE_CYC  = RECHARGE_US * (CLK_HZ / 1_000_000);
	localparam int          PWM_LOW_CYC   = PWM_LOW_US * (CLK_HZ / 1_000_000);
	localparam int          TEMP_SMP_CYC  = TEMP_SMP_US * (CLK_HZ / 1_000_000);
	// gate supply sequencing
	typedef enum logic [3:0] {
		GS_OFF   = 4'h1,
		GS_START = 4'h2,
		GS_RUN   = 4'h4,
		GS_FAULT = 4'h8
	} lds_gs_e;
endpackage : lds_pkg

// File: verilog/lds_cmd_if.sv
// command frames between serial engine and register logic
interface lds_cmd_if;
	logic        done; // one-cycle pulse at frame end
	logic        bad;  // bit count not a whole word
	logic [15:0] cmd;  // last sixteen bits received
	logic [15:0] tx;   // word to shift out on next frame
	modport eng (output done, output bad, output cmd, input tx);
	modport regs (input done, input bad, input cmd, output tx);
endinterface : lds_cmd_if

// File: verilog/lds_spi_frame.sv
// serial frame engine, mode 0, msb first, pins sampled on clk_i
module lds_spi_frame (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic sck_i,
	input  wire logic cs_n_i,
	input  wire logic mosi_i,
	output logic      miso_o,
	output logic      miso_oe_o,
	lds_cmd_if.eng    cmd_if
);
	typedef struct packed {
		logic        sck_p;  // last sck level
		logic        cs_p;   // last cs_n level
		logic        any;    // at least one bit seen
		logic [3:0]  cnt;    // bits modulo sixteen
		logic [15:0] sin;    // receive shifter
		logic [15:0] sout;   // transmit shifter
		logic        miso;
		logic        oe;
		logic        done;
		logic        bad;
		logic [15:0] cmd;
	} lds_eng_s;

	lds_eng_s q, d;

	// edge detection and shifting
	always_comb begin
		d      = q;
		d.sck_p = sck_i;
		d.cs_p  = cs_n_i;
		d.done  = 1'b0;
		if (q.cs_p && !cs_n_i) begin // frame opens
			d.sout = cmd_if.tx;
			d.miso = cmd_if.tx[15];
			d.oe   = 1'b1;
			d.cnt  = 4'h0;
			d.any  = 1'b0;
		end else if (!q.cs_p && cs_n_i) begin // frame closes
			d.oe   = 1'b0;
			d.done = 1'b1;
			d.bad  = (q.cnt != 4'h0) || !q.any;
			d.cmd  = q.sin;
		end else if (!cs_n_i) begin
			if (sck_i && !q.sck_p) begin // sample on rising edge
				d.sin = {q.sin[14:0], mosi_i};
				d.cnt = q.cnt + 4'h1;
				d.any = 1'b1;
			end else if (!sck_i && q.sck_p) begin // present on falling edge
				d.sout = {q.sout[14:0], 1'b0};
				d.miso = q.sout[14];
			end
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '{sck_p: 1'b0, cs_p: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign miso_o     = q.miso;
	assign miso_oe_o  = q.oe;
	assign cmd_if.done = q.done;
	assign cmd_if.bad  = q.bad;
	assign cmd_if.cmd  = q.cmd;

	// short or ragged frames are always flagged
	property p_short_frame;
		@(posedge clk_i) disable iff (!arst_n_i)
		(!q.cs_p && cs_n_i && q.cnt != 4'h0) |=> (q.done && q.bad);
	endproperty
	a_short_frame: assert property (p_short_frame) else $error("ragged frame not flagged");
endmodule : lds_spi_frame

// File: dv/lds_spi_host.sv
// controller model: mode 0 master, msb first, paced well above the minima
module lds_spi_host (
	input  wire logic clk_i,
	input  wire logic miso_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      mosi_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle: deselected, clock stands low
	initial begin
		sck_o  = 1'h0;
		cs_n_o = 1'h1;
		mosi_o = 1'h0;
	end

	// step past a number of edges, then move off the edge
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick

	// one frame of n bits; r gets what the device shifted out meanwhile
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'h0000;
		tick(1);
		cs_n_o = 1'h0;
		tick(2);
		for (int i = n - 1; i >= 0; i--) begin
			mosi_o = w[i];
			tick(2);
			sck_o = 1'h1;
			r = {r[14:0], miso_i}; // taken at the rising clock
			tick(2);
			sck_o = 1'h0;
		end
		tick(2);
		cs_n_o = 1'h1;
		mosi_o = ~mosi_o; // released line must not keep its last value
		tick(4); // cs high long enough before the next frame
	endtask : xfer
endmodule : lds_spi_host

// File: dv/tb_top.sv
// register-level bench: sequences of serial accesses and pin stimulus
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i    = 1'h0;
	logic        arst_n_i = 1'h0;
	logic        sck, cs_n, mosi, miso, miso_oe; // serial pins
	logic        en = 1'h0, sup = 1'h0, hot = 1'h0, inreg = 1'h0, clr = 1'h0;
	logic [7:0]  temp = 8'h00, diag2 = 8'h00;   // converter and diag inputs
	logic [1:0]  pwm = 2'h0, live = 2'h0, bsuv = 2'h0, lowhr = 2'h0;
	logic        ack, reg_en, drv_en, vled;
	logic [1:0]  cur_en, rchg, comp;
	logic [7:0]  status, die_t;
	logic [15:0] rep;                            // reply of the previous frame
	logic [15:0] bad_w [3];                      // commands that must be refused
	int          bad_n [3];
	int          err_count = 0, checks_done = 0, cyc = 0, n;

	// 50 ns clock
	initial begin
		forever #25 clk_i = ~clk_i;
	end

	// hang guard, far above the few thousand cycles the run needs
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end

	lds_spi_host host (.clk_i(clk_i), .miso_i(miso), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

	// short timeouts keep the gate supply cases quick
	lds_diag_status #(.START_TMO(200), .RUN_TMO(50)) dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .enable_i(en),
		.supply_above_uv_i(sup), .overtemp_i(hot), .gate_supply_in_reg_i(inreg),
		.temp_code_i(temp), .diag2_i(diag2), .pwm_i(pwm), .live_current_reached_i(live),
		.bs_uv_i(bsuv), .low_headroom_i(lowhr), .fault_clear_req_i(clr),
		.fault_clear_ack_o(ack), .gate_reg_en_o(reg_en), .gate_drv_en_o(drv_en),
		.ch_current_en_o(cur_en), .vled_meas_upd_o(vled), .recharge_o(rchg),
		.bs_comp_en_o(comp), .status_o(status), .die_temperature_o(die_t)
	);

	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick

	function automatic logic [15:0] rd(input logic [6:0] a);
		return {1'h0, a, 8'h00};
	endfunction : rd

	function automatic logic [15:0] wr(input logic [6:0] a, input logic [7:0] d);
		return {1'h1, a, d};
	endfunction : wr

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: byte %h, want %h", $time, g, e);
		end
	endtask : chk8

	task automatic chkb(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: bit %b, want %b", $time, g, e);
		end
	endtask : chkb

	// bounded wait for one status bit, then compare it
	task automatic wait_st(input int i, input logic v, input int k);
		for (int j = 0; j < k && status[i] !== v; j++) tick(1);
		chkb(status[i], v);
	endtask : wait_st

	task automatic end_sim();
		$display("checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim

	// main sequence
	initial begin
		bad_w[0] = wr(lds_pkg::ADDR_TEMP, 8'h55); // write to read-only place
		bad_n[0] = 16;
		bad_w[1] = rd(lds_pkg::ADDR_STATUS);      // short frame
		bad_n[1] = 15;
		bad_w[2] = rd(7'h10);                     // read of reserved place
		bad_n[2] = 16;
		tick(6);
		arst_n_i = 1'h1;
		tick(1);
		chk8(status, 8'h00);
		chkb(reg_en, 1'h0);
		sup = 1'h1;
		en  = 1'h1;
		wait_st(lds_pkg::ST_SUPPLY, 1'h1, 5);
		tick(4);
		chkb(reg_en, 1'h1);
		inreg = 1'h1;
		wait_st(lds_pkg::ST_GS_GOOD, 1'h1, 10);
		pwm = 2'h1;
		tick(4);
		chk8({6'h0, cur_en}, 8'h01);
		chkb(vled, 1'h1);
		chk8({6'h0, comp}, 8'h02);
		bsuv = 2'h2;
		tick(3);
		chkb(comp[1], 1'h0);
		bsuv = 2'h0;
		lowhr = 2'h2;
		tick(3);
		chkb(comp[1], 1'h0);
		lowhr = 2'h0;
		live = 2'h1;
		tick(2);
		pwm = 2'h0; // falling edge latches the live bits
		tick(3);
		chk8({6'h0, status[1:0]}, 8'h01);
		// recharge only starts once pwm has been low past the long-low delay
		tick(lds_pkg::PWM_LOW_CYC);
		// two temperature codes, 8'hAF then 8'hD8, recharge counted meanwhile
		foreach (bad_n[i]) begin
			if (i < 2) begin
				temp = (i == 0) ? 8'hAF : 8'hD8;
				n = 0;
				repeat (2100) begin
					tick(1);
					if (rchg[1] === 1'h1) n++;
				end
				chkb(n >= 1 && n <= 2, 1'h1);
				chk8(die_t, temp);
				host.xfer(rd(lds_pkg::ADDR_TEMP), 16, rep);
				host.xfer(rd(lds_pkg::ADDR_STATUS), 16, rep);
				chk8(rep[7:0], temp);
				chk8(rep[15:8], 8'h89);
				chkb(miso_oe, 1'h0);
			end
		end
		diag2 = 8'h3C;
		// each refused frame flags, answers with diagnostics, status write clears
		for (int i = 0; i < 3; i++) begin
			host.xfer(bad_w[i], bad_n[i], rep);
			tick(2);
			chkb(status[lds_pkg::ST_CMD_ERR], 1'h1);
			host.xfer(wr(lds_pkg::ADDR_STATUS, 8'hFF), 16, rep);
			chk8(rep[7:0], 8'h3C);
			tick(2);
			chk8(status, 8'h89);
		end
		chk8(die_t, 8'hD8);
		pwm = 2'h1;
		hot = 1'h1;
		wait_st(lds_pkg::ST_OVERTEMP, 1'h1, 5);
		tick(4);
		chk8({4'h0, reg_en, drv_en, cur_en}, 8'h00);
		chk8({6'h0, status[4:3]}, 8'h02);
		clr = 1'h1; // a request while still hot must not clear
		tick(5);
		chkb(status[lds_pkg::ST_OVERTEMP], 1'h1);
		hot = 1'h0;
		tick(5);
		chk8({6'h0, status[5:4]}, 8'h00);
		chkb(ack, 1'h1);
		clr = 1'h0;
		tick(2);
		chkb(ack, 1'h0);
		wait_st(lds_pkg::ST_GS_GOOD, 1'h1, 20);
		inreg = 1'h0;
		tick(40);
		chkb(status[lds_pkg::ST_GS_FAULT], 1'h0);
		wait_st(lds_pkg::ST_GS_FAULT, 1'h1, 20);
		tick(2);
		chk8({5'h0, drv_en, reg_en, vled}, 8'h00);
		en = 1'h0;
		wait_st(lds_pkg::ST_GS_FAULT, 1'h0, 5);
		en = 1'h1;
		tick(185);
		chkb(status[lds_pkg::ST_GS_FAULT], 1'h0);
		wait_st(lds_pkg::ST_GS_FAULT, 1'h1, 30);
		sup = 1'h0;
		tick(3);
		chk8(status, 8'h10);
		chk8({4'h0, reg_en, drv_en, cur_en}, 8'h00);
		chkb(vled, 1'h0);
		clr = 1'h1;
		tick(3);
		clr = 1'h0;
		chkb(status[lds_pkg::ST_GS_FAULT], 1'h0);
		tick(260);
		chkb(status[lds_pkg::ST_GS_FAULT], 1'h0);
		end_sim();
	end
endmodule : tb_top
